// *** design/dmc_pkg.sv ***
// shared constants and carrier types for the datapath mode configuration bank
package dmc_pkg;

    localparam int NCH = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 14;
    localparam int DECIM_W = 5;

    // register byte addresses on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_CHAN_SELECT = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_CHIP_OPERATING_MODE = 12'h200;
    localparam logic [ADDR_W-1:0] ADDR_CHIP_RATE_REDUCTION = 12'h201;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_SIGNED_OFFSET = 12'h228;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_THRESHOLD_PIN_CONTROL = 12'h245;

    // reset values
    localparam logic [DATA_W-1:0] RST_CHAN_SELECT = 8'h0f;
    localparam logic [DATA_W-1:0] RST_CHIP_OPERATING_MODE = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHIP_RATE_REDUCTION = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHANNEL_SIGNED_OFFSET = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHANNEL_THRESHOLD_PIN_CONTROL = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // writable bit masks; cleared positions are read-only and read as zero
    localparam logic [DATA_W-1:0] MASK_CHAN_SELECT = 8'h0f;
    localparam logic [DATA_W-1:0] MASK_CHIP_OPERATING_MODE = 8'hef;
    localparam logic [DATA_W-1:0] MASK_CHIP_RATE_REDUCTION = 8'h07;
    localparam logic [DATA_W-1:0] MASK_CHANNEL_SIGNED_OFFSET = 8'hff;
    localparam logic [DATA_W-1:0] MASK_CHANNEL_THRESHOLD_PIN_CONTROL = 8'h0d;

    // field positions
    localparam int MODE_APP_LSB = 0;
    localparam int MODE_APP_W = 4;
    localparam int MODE_REAL_ONLY_BIT = 5;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam int FLAG_ENABLE_BIT = 0;
    localparam int FLAG_FORCE_VALUE_BIT = 2;
    localparam int FLAG_FORCE_BIT = 3;

    // application mode codes
    localparam logic [MODE_APP_W-1:0] APP_FULL_BANDWIDTH = 4'h0;
    localparam logic [MODE_APP_W-1:0] APP_ONE_CHANNEL = 4'h1;
    localparam logic [MODE_APP_W-1:0] APP_TWO_CHANNELS = 4'h2;
    localparam logic [1:0] CONV_NONE = 2'h0;
    localparam logic [1:0] CONV_CH0 = 2'h1;
    localparam logic [1:0] CONV_CH0_CH1 = 2'h3;

    // rate reduction codes and the factors they select
    localparam logic [RATE_W-1:0] RATE_BY_1 = 3'h0;
    localparam logic [RATE_W-1:0] RATE_BY_2 = 3'h1;
    localparam logic [RATE_W-1:0] RATE_BY_4 = 3'h2;
    localparam logic [RATE_W-1:0] RATE_BY_8 = 3'h3;
    localparam logic [RATE_W-1:0] RATE_BY_16 = 3'h4;
    localparam logic [DECIM_W-1:0] FACTOR_1 = 5'h01;
    localparam logic [DECIM_W-1:0] FACTOR_2 = 5'h02;
    localparam logic [DECIM_W-1:0] FACTOR_4 = 5'h04;
    localparam logic [DECIM_W-1:0] FACTOR_8 = 5'h08;
    localparam logic [DECIM_W-1:0] FACTOR_16 = 5'h10;

    // saturation limits of the converter word
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 14'h1fff;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 14'h2000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dmc_bus_s;

    typedef struct packed {
        logic full_bandwidth;
        logic [1:0] down_conversion_channel;
        logic real_only;
        logic [DECIM_W-1:0] decim_factor;
        logic mode_invalid;
        logic rate_invalid;
    } dmc_cfg_s;

endpackage

// *** design/dmc_mode_dec.sv ***
// decoder from the chip mode and rate registers to datapath configuration
`timescale 1ns/1ps
module dmc_mode_dec (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dmc_pkg::DATA_W-1:0] mode_reg,
    input wire logic [dmc_pkg::DATA_W-1:0] rate_reg,
    output dmc_pkg::dmc_cfg_s cfg
);
    dmc_pkg::dmc_cfg_s st_r;
    dmc_pkg::dmc_cfg_s st_nxt;
    logic [dmc_pkg::MODE_APP_W-1:0] app;
    logic [dmc_pkg::RATE_W-1:0] rate;

    assign app = mode_reg[dmc_pkg::MODE_APP_LSB +: dmc_pkg::MODE_APP_W];
    assign rate = rate_reg[dmc_pkg::RATE_LSB +: dmc_pkg::RATE_W];

    always_comb begin
        st_nxt = st_r;
        // q is dropped when the real-only bit is set
        st_nxt.real_only = mode_reg[dmc_pkg::MODE_REAL_ONLY_BIT];
        st_nxt.mode_invalid = 1'b0;
        // unlisted codes fall back to full bandwidth so no channel runs half set up
        unique case (app)
            dmc_pkg::APP_FULL_BANDWIDTH: begin
                st_nxt.full_bandwidth = 1'b1;
                st_nxt.down_conversion_channel = dmc_pkg::CONV_NONE;
            end
            dmc_pkg::APP_ONE_CHANNEL: begin
                st_nxt.full_bandwidth = 1'b0;
                st_nxt.down_conversion_channel = dmc_pkg::CONV_CH0;
            end
            dmc_pkg::APP_TWO_CHANNELS: begin
                st_nxt.full_bandwidth = 1'b0;
                st_nxt.down_conversion_channel = dmc_pkg::CONV_CH0_CH1;
            end
            default: begin
                st_nxt.full_bandwidth = 1'b1;
                st_nxt.down_conversion_channel = dmc_pkg::CONV_NONE;
                st_nxt.mode_invalid = 1'b1;
            end
        endcase
        st_nxt.rate_invalid = 1'b0;
        unique case (rate)
            dmc_pkg::RATE_BY_1: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_1;
            end
            dmc_pkg::RATE_BY_2: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_2;
            end
            dmc_pkg::RATE_BY_4: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_4;
            end
            dmc_pkg::RATE_BY_8: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_8;
            end
            dmc_pkg::RATE_BY_16: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_16;
            end
            default: begin
                st_nxt.decim_factor = dmc_pkg::FACTOR_1;
                st_nxt.rate_invalid = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '{full_bandwidth: 1'b1, down_conversion_channel: dmc_pkg::CONV_NONE,
                      real_only: 1'b0,
                      decim_factor: dmc_pkg::FACTOR_1, mode_invalid: 1'b0,
                      rate_invalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg = st_r;
endmodule // dmc_mode_dec

// *** design/dmc_chan.sv ***
// one channel: signed offset on the sample path and the threshold flag pin
`timescale 1ns/1ps
module dmc_chan (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [dmc_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid,
    input wire logic detect_in,
    input wire logic [dmc_pkg::DATA_W-1:0] offset,
    input wire logic [dmc_pkg::DATA_W-1:0] pin_ctrl,
    output logic [dmc_pkg::SAMPLE_W-1:0] data_out,
    output logic data_valid,
    output logic flag_pin
);
    typedef struct packed {
        logic [dmc_pkg::SAMPLE_W-1:0] data;
        logic valid;
        logic pin;
    } dmc_chan_state_s;

    dmc_chan_state_s st_r;
    dmc_chan_state_s st_nxt;
    logic signed [dmc_pkg::SAMPLE_W:0] sum;

    // one extra bit catches overflow; offset lands on the converter lsb
    assign sum = $signed({sample_in[dmc_pkg::SAMPLE_W-1], sample_in})
               + $signed({{(dmc_pkg::SAMPLE_W+1-dmc_pkg::DATA_W){offset[dmc_pkg::DATA_W-1]}},
                          offset});

    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = sample_valid;
        if (sample_valid) begin
            // saturate rather than wrap so a big offset cannot flip the sign
            if (sum[dmc_pkg::SAMPLE_W] != sum[dmc_pkg::SAMPLE_W-1]) begin
                st_nxt.data = sum[dmc_pkg::SAMPLE_W] ? dmc_pkg::SAMPLE_MIN
                                                      : dmc_pkg::SAMPLE_MAX;
            end else begin
                st_nxt.data = sum[dmc_pkg::SAMPLE_W-1:0];
            end
        end
        if (pin_ctrl[dmc_pkg::FLAG_FORCE_BIT]) begin
            st_nxt.pin = pin_ctrl[dmc_pkg::FLAG_FORCE_VALUE_BIT];
        end else begin
            st_nxt.pin = pin_ctrl[dmc_pkg::FLAG_ENABLE_BIT] & detect_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '{data: '0, valid: 1'b0, pin: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_out = st_r.data;
    assign data_valid = st_r.valid;
    assign flag_pin = st_r.pin;
endmodule // dmc_chan

// *** design/dmc_regs.sv ***
// register bank for datapath mode, rate, per-channel offset and flag pin control
// Behaviour
// - The real-only bit at 0 keeps I and Q, at 1 drops Q and keeps only I.
// - Application mode 0000 is full bandwidth, 0001 channel 0 only, 0010 channels 0 and 1.
// - Rate code 000 passes the full rate, 001 to 100 reduce by 2, 4, 8 and 16.
// - Each channel adds its own signed 8-bit offset at the converter lsb.
// - With force clear, the flag pin follows the normal detection logic.
// - With force set, the flag pin shows the force value bit.
// - The enable bit turns fine detection on at 1 and off at 0.
`timescale 1ns/1ps
module dmc_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire dmc_pkg::dmc_bus_s bus,
    output logic [dmc_pkg::DATA_W-1:0] rdata,
    input wire logic [dmc_pkg::NCH-1:0][dmc_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic [dmc_pkg::NCH-1:0] sample_valid,
    input wire logic [dmc_pkg::NCH-1:0] detect_in,
    output logic [dmc_pkg::NCH-1:0][dmc_pkg::SAMPLE_W-1:0] data_out,
    output logic [dmc_pkg::NCH-1:0] data_valid,
    output logic [dmc_pkg::NCH-1:0] threshold_flag_pins,
    output dmc_pkg::dmc_cfg_s cfg
);
    typedef struct packed {
        logic [dmc_pkg::DATA_W-1:0] chan_select;
        logic [dmc_pkg::DATA_W-1:0] chip_operating_mode;
        logic [dmc_pkg::DATA_W-1:0] chip_rate_reduction;
        logic [dmc_pkg::NCH-1:0][dmc_pkg::DATA_W-1:0] channel_signed_offset;
        logic [dmc_pkg::NCH-1:0][dmc_pkg::DATA_W-1:0] channel_threshold_pin_control;
        logic [dmc_pkg::DATA_W-1:0] rdata;
    } dmc_regs_state_s;

    dmc_regs_state_s st_r;
    dmc_regs_state_s st_nxt;
    logic [dmc_pkg::DATA_W-1:0] read_value;
    logic [dmc_pkg::NCH-1:0] read_chan_onehot;

    // reads of channel registers come from the lowest selected channel;
    // with several selected, software sees only that one copy
    always_comb begin
        read_chan_onehot = '0;
        for (int i = dmc_pkg::NCH - 1; i >= 0; i--) begin
            if (st_r.chan_select[i]) begin
                read_chan_onehot = '0;
                read_chan_onehot[i] = 1'b1;
            end
        end
    end

    always_comb begin
        read_value = dmc_pkg::DATA_ZERO;
        unique case (bus.addr)
            dmc_pkg::ADDR_CHAN_SELECT: begin
                read_value = st_r.chan_select;
            end
            dmc_pkg::ADDR_CHIP_OPERATING_MODE: begin
                read_value = st_r.chip_operating_mode;
            end
            dmc_pkg::ADDR_CHIP_RATE_REDUCTION: begin
                read_value = st_r.chip_rate_reduction;
            end
            dmc_pkg::ADDR_CHANNEL_SIGNED_OFFSET: begin
                for (int i = 0; i < dmc_pkg::NCH; i++) begin
                    if (read_chan_onehot[i]) begin
                        read_value = st_r.channel_signed_offset[i];
                    end
                end
            end
            dmc_pkg::ADDR_CHANNEL_THRESHOLD_PIN_CONTROL: begin
                for (int i = 0; i < dmc_pkg::NCH; i++) begin
                    if (read_chan_onehot[i]) begin
                        read_value = st_r.channel_threshold_pin_control[i];
                    end
                end
            end
            default: begin
                read_value = dmc_pkg::DATA_ZERO;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // read data stand for exactly one cycle, zero otherwise
        st_nxt.rdata = bus.rd ? read_value : dmc_pkg::DATA_ZERO;
        if (bus.wr) begin
            // masks keep read-only positions at zero whatever is written
            unique case (bus.addr)
                dmc_pkg::ADDR_CHAN_SELECT: begin
                    st_nxt.chan_select = bus.wdata & dmc_pkg::MASK_CHAN_SELECT;
                end
                dmc_pkg::ADDR_CHIP_OPERATING_MODE: begin
                    st_nxt.chip_operating_mode =
                        bus.wdata & dmc_pkg::MASK_CHIP_OPERATING_MODE;
                end
                dmc_pkg::ADDR_CHIP_RATE_REDUCTION: begin
                    st_nxt.chip_rate_reduction =
                        bus.wdata & dmc_pkg::MASK_CHIP_RATE_REDUCTION;
                end
                dmc_pkg::ADDR_CHANNEL_SIGNED_OFFSET: begin
                    for (int i = 0; i < dmc_pkg::NCH; i++) begin
                        if (st_r.chan_select[i]) begin
                            st_nxt.channel_signed_offset[i] =
                                bus.wdata & dmc_pkg::MASK_CHANNEL_SIGNED_OFFSET;
                        end
                    end
                end
                dmc_pkg::ADDR_CHANNEL_THRESHOLD_PIN_CONTROL: begin
                    for (int i = 0; i < dmc_pkg::NCH; i++) begin
                        if (st_r.chan_select[i]) begin
                            st_nxt.channel_threshold_pin_control[i] =
                                bus.wdata & dmc_pkg::MASK_CHANNEL_THRESHOLD_PIN_CONTROL;
                        end
                    end
                end
                default: begin
                    st_nxt.rdata = st_nxt.rdata;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r.chan_select <= dmc_pkg::RST_CHAN_SELECT;
            st_r.chip_operating_mode <= dmc_pkg::RST_CHIP_OPERATING_MODE;
            st_r.chip_rate_reduction <= dmc_pkg::RST_CHIP_RATE_REDUCTION;
            st_r.channel_signed_offset <= {dmc_pkg::NCH{dmc_pkg::RST_CHANNEL_SIGNED_OFFSET}};
            st_r.channel_threshold_pin_control <=
                {dmc_pkg::NCH{dmc_pkg::RST_CHANNEL_THRESHOLD_PIN_CONTROL}};
            st_r.rdata <= dmc_pkg::DATA_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;

    // decoded settings lag the register by one cycle, harmless for static config
    dmc_mode_dec u_mode_dec (
        .mclk(mclk),
        .reset(reset),
        .mode_reg(st_r.chip_operating_mode),
        .rate_reg(st_r.chip_rate_reduction),
        .cfg(cfg)
    );

    for (genvar g = 0; g < dmc_pkg::NCH; g++) begin : g_chan
        dmc_chan u_chan (
            .mclk(mclk),
            .reset(reset),
            .sample_in(sample_in[g]),
            .sample_valid(sample_valid[g]),
            .detect_in(detect_in[g]),
            .offset(st_r.channel_signed_offset[g]),
            .pin_ctrl(st_r.channel_threshold_pin_control[g]),
            .data_out(data_out[g]),
            .data_valid(data_valid[g]),
            .flag_pin(threshold_flag_pins[g])
        );
    end
endmodule // dmc_regs

// *** bench/dmc_regs_asserts.sv ***
// concurrent checks on the ports of the datapath mode configuration bank
`timescale 1ns/1ps
module dmc_regs_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire dmc_pkg::dmc_bus_s bus,
    input wire logic [dmc_pkg::DATA_W-1:0] rdata,
    input wire logic [dmc_pkg::NCH-1:0] detect_in,
    input wire logic [dmc_pkg::NCH-1:0] sample_valid,
    input wire logic [dmc_pkg::NCH-1:0] data_valid,
    input wire logic [dmc_pkg::NCH-1:0] threshold_flag_pins,
    input wire dmc_pkg::dmc_cfg_s cfg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic wr_mode;
    logic wr_rate;
    logic wr_flag;
    logic [3:0] sel_r;
    assign wr_mode = bus.wr && bus.addr == 12'h200;
    assign wr_rate = bus.wr && bus.addr == 12'h201;
    assign wr_flag = bus.wr && bus.addr == 12'h245;

    // shadow of the channel select register, so per-channel checks see only selected lanes
    always_ff @(posedge mclk) begin
        if (reset) begin
            sel_r <= 4'hf;
        end else if (bus.wr && bus.addr == 12'h008) begin
            sel_r <= bus.wdata[3:0];
        end
    end

    // bits a write then read shows per address; zero marks an unmapped place,
    // and channel registers read zero while no channel is selected
    function automatic logic [7:0] wmask(input logic [11:0] a, input logic [3:0] sel);
        case (a)
            12'h008: wmask = 8'h0f;
            12'h200: wmask = 8'hef;
            12'h201: wmask = 8'h07;
            12'h228: wmask = (sel != 4'h0) ? 8'hff : 8'h00;
            12'h245: wmask = (sel != 4'h0) ? 8'h0d : 8'h00;
            default: wmask = 8'h00;
        endcase
    endfunction

    sequence seq_wr_rd;
        bus.wr ##1 (bus.rd && bus.addr == $past(bus.addr));
    endsequence
    // a control write that is not overwritten in the next cycle
    sequence seq_flag_wr(f);
        wr_flag && bus.wdata[3] == f ##1 !wr_flag;
    endsequence

    AST_RDATA_IDLE: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_WR_RD: assert property (seq_wr_rd |=>
        rdata == ($past(bus.wdata, 2) & wmask($past(bus.addr, 2), sel_r)))
        else $error("read after write differs from writable bits");
    AST_UNMAPPED: assert property (bus.rd && wmask(bus.addr, sel_r) == 8'h00 |=>
        rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_REAL_ONLY: assert property (wr_mode |-> ##2 cfg.real_only == $past(bus.wdata[5], 2))
        else $error("real only flag wrong");
    AST_APP_FULL: assert property (wr_mode && bus.wdata[3:0] == 4'h0 |->
        ##2 cfg.full_bandwidth && cfg.down_conversion_channel == 2'h0)
        else $error("full bandwidth decode wrong");
    AST_APP_DDC: assert property (wr_mode && bus.wdata[3:0] inside {4'h1, 4'h2} |->
        ##2 !cfg.full_bandwidth && cfg.down_conversion_channel == {$past(bus.wdata[1], 2), 1'b1})
        else $error("channel enable decode wrong");
    AST_RATE: assert property (wr_rate && bus.wdata[2:0] <= 3'h4 |->
        ##2 cfg.decim_factor == (5'h01 << $past(bus.wdata[2:0], 2)))
        else $error("rate factor wrong");
    AST_FLAG_FORCE: assert property (seq_flag_wr(1'b1) |=>
        (threshold_flag_pins & $past(sel_r, 2)) ==
        ({4{$past(bus.wdata[2], 2)}} & $past(sel_r, 2)))
        else $error("forced flag pins wrong");
    AST_FLAG_NORMAL: assert property (seq_flag_wr(1'b0) |=>
        (threshold_flag_pins & $past(sel_r, 2)) ==
        ({4{$past(bus.wdata[0], 2)}} & $past(detect_in) & $past(sel_r, 2)))
        else $error("normal flag pins wrong");
    AST_VALID: assert property (sample_valid[0] |=> data_valid[0])
        else $error("data valid missing");
    AST_VALID_ALL: assert property (1'b1 |=> data_valid == $past(sample_valid))
        else $error("data valid does not follow the sample qualifier");
endmodule // dmc_regs_chk

bind dmc_regs dmc_regs_chk chk_u (
    .mclk(mclk),
    .reset(reset),
    .bus(bus),
    .rdata(rdata),
    .detect_in(detect_in),
    .sample_valid(sample_valid),
    .data_valid(data_valid),
    .threshold_flag_pins(threshold_flag_pins),
    .cfg(cfg)
);

// *** bench/dmc_regs_tb.sv ***
// self-checking testbench for the datapath mode configuration bank
`timescale 1ns/1ps
module dmc_regs_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    dmc_pkg::dmc_bus_s bus = '0;
    logic [7:0] rdata;
    logic [3:0][13:0] sample_in = '0;
    logic [3:0] sample_valid = 4'hf;
    logic [3:0] detect_in = 4'h0;
    logic [3:0][13:0] data_out;
    logic [3:0] data_valid;
    logic [3:0] threshold_flag_pins;
    dmc_pkg::dmc_cfg_s cfg;
    int err_total = 0;
    int cmp_count = 0;

    always #50 mclk = ~mclk;

    dmc_regs dut_u (
        .mclk(mclk),
        .reset(reset),
        .bus(bus),
        .rdata(rdata),
        .sample_in(sample_in),
        .sample_valid(sample_valid),
        .detect_in(detect_in),
        .data_out(data_out),
        .data_valid(data_valid),
        .threshold_flag_pins(threshold_flag_pins),
        .cfg(cfg)
    );

    task automatic fail(input string msg);
        err_total++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("byte %h exp %h", got, exp));
    endtask
    task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("sample %h exp %h", got, exp));
    endtask
    task automatic chk_bits(input logic [4:0] got, input logic [4:0] exp);
        cmp_count++;
        if (got !== exp) fail($sformatf("bits %h exp %h", got, exp));
    endtask

    task automatic drive(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask
    // idle cycles also drop any strobe left up by a write
    task automatic wait_cyc(input int n);
        repeat (n) drive(1'b0, 1'b0, 12'h000, 8'h00);
        #1;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        drive(1'b0, 1'b1, a, 8'h00);
        wait_cyc(1);
        chk_byte(rdata, exp);
    endtask

    task automatic t_reset();
        rd_chk(12'h200, 8'h00);
        rd_chk(12'h201, 8'h00);
        rd_chk(12'h228, 8'h00);
        rd_chk(12'h245, 8'h00);
        chk_bits(cfg.decim_factor, 5'h01);
        chk_bits({4'h0, cfg.full_bandwidth}, 5'h01);
    endtask

    task automatic t_modes();
        logic [7:0] d;
        for (int i = 0; i < 3; i++) begin
            // reserved bit 4 is written high every time and must stay zero
            d = 8'h10 | (i == 1 ? 8'h20 : 8'h00) | 8'(i);
            wr_reg(12'h200, d);
            rd_chk(12'h200, d & 8'hef);
            chk_bits({1'b0, cfg.real_only, cfg.full_bandwidth, cfg.down_conversion_channel},
                {1'b0, d[5], i == 0, i == 2, i != 0});
        end
    endtask

    task automatic t_rates();
        for (int i = 0; i < 5; i++) begin
            wr_reg(12'h201, 8'hf8 | 8'(i));
            rd_chk(12'h201, 8'(i));
            chk_bits(cfg.decim_factor, 5'(1 << i));
        end
    endtask

    task automatic off_case(input logic [7:0] off, input logic [13:0] s, input logic [13:0] exp);
        wr_reg(12'h228, off);
        sample_in <= {4{s}};
        wait_cyc(3);
        for (int c = 0; c < 4; c++) begin
            chk_word(data_out[c], exp);
        end
    endtask

    task automatic flag_case(input logic [7:0] ctl, input logic [3:0] det, input logic [3:0] exp);
        wr_reg(12'h245, ctl);
        detect_in <= det;
        wait_cyc(3);
        chk_bits({1'b0, threshold_flag_pins}, {1'b0, exp});
    endtask

    // unlisted codes are kept as written but decode to the safe defaults
    task automatic t_invalid();
        wr_reg(12'h200, 8'hc3);
        rd_chk(12'h200, 8'hc3);
        chk_bits({cfg.mode_invalid, cfg.real_only, cfg.full_bandwidth,
            cfg.down_conversion_channel}, 5'h14);
        wr_reg(12'h201, 8'h05);
        rd_chk(12'h201, 8'h05);
        chk_bits({cfg.rate_invalid, cfg.decim_factor[3:0]}, 5'h11);
        chk_bits(cfg.decim_factor, 5'h01);
        wr_reg(12'h200, 8'h00);
        wr_reg(12'h201, 8'h00);
        wait_cyc(2);
        chk_bits({3'h0, cfg.mode_invalid, cfg.rate_invalid}, 5'h00);
    endtask

    // outputs keep the last sample while the qualifier is low
    task automatic t_hold();
        @(posedge mclk);
        sample_valid <= 4'h0;
        sample_in <= {4{14'h0123}};
        wait_cyc(2);
        chk_bits({1'b0, data_valid}, 5'h00);
        for (int c = 0; c < 4; c++) begin
            chk_word(data_out[c], 14'h2000);
        end
        @(posedge mclk);
        sample_valid <= 4'hf;
        wait_cyc(2);
        chk_bits({1'b0, data_valid}, 5'h0f);
        for (int c = 0; c < 4; c++) begin
            chk_word(data_out[c], 14'h00a3);
        end
    endtask

    // only selected channels take a write; reads come from the lowest selected one
    task automatic t_chan_select();
        wr_reg(12'h008, 8'hf2);
        rd_chk(12'h008, 8'h02);
        wr_reg(12'h228, 8'h01);
        wait_cyc(3);
        chk_word(data_out[0], 14'h00a3);
        chk_word(data_out[1], 14'h0124);
        rd_chk(12'h228, 8'h01);
        wr_reg(12'h008, 8'h00);
        rd_chk(12'h228, 8'h00);
        wr_reg(12'h228, 8'h7f);
        wr_reg(12'h008, 8'h0f);
        rd_chk(12'h228, 8'h80);
        wr_reg(12'h228, 8'h80);
    endtask

    task automatic t_reserved();
        wr_reg(12'h245, 8'hff);
        rd_chk(12'h245, 8'h0d);
        wr_reg(12'h202, 8'hff);
        rd_chk(12'h202, 8'h00);
        rd_chk(12'h1ff, 8'h00);
    endtask

    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        wait_cyc(1);
        t_reset();
        t_modes();
        t_rates();
        t_invalid();
        off_case(8'h7f, 14'h0064, 14'h00e3);
        off_case(8'h7f, 14'h1fff, 14'h1fff);
        off_case(8'h80, 14'h0064, 14'h3fe4);
        off_case(8'h80, 14'h2000, 14'h2000);
        rd_chk(12'h228, 8'h80);
        t_hold();
        t_chan_select();
        flag_case(8'h01, 4'ha, 4'ha);
        flag_case(8'h01, 4'h5, 4'h5);
        flag_case(8'h00, 4'hf, 4'h0);
        flag_case(8'h0c, 4'h0, 4'hf);
        flag_case(8'h09, 4'hf, 4'h0);
        t_reserved();
        wait_cyc(2);
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fail("timeout");
        finish_test();
    end
endmodule // dmc_regs_tb
